// ===== gdfs_apb_host.sv
`timescale 1ns/1ps
// Host controller: APB master, waits for pready
module gdfs_apb_host (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
  end
  // One transfer; held until pready seen high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : gdfs_apb_host

// ===== gdfs_evt_cell.sv
`timescale 1ns/1ps
// One sticky event bit; a set in the clear cycle wins
module gdfs_evt_cell (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);

  typedef struct packed {
    logic flag;
  } gdfs_cell_state_s;

  gdfs_cell_state_s st_r;
  gdfs_cell_state_s st_nxt;

  // Set has priority over clear
  always_comb begin
    st_nxt      = st_r;
    st_nxt.flag = set_i | (st_r.flag & ~clr_i);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag_o = st_r.flag;

endmodule : gdfs_evt_cell

// ===== gdfs_fault_status.sv
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module gdfs_fault_status
  import gdfs_pkg::*;
#(
  parameter int ADDR_W  = GDFS_ADDR_W,
  parameter int NUM_SRC = GDFS_NUM_SRC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  input  wire gdfs_fault_s       fault_in,
  input  wire logic [31:0]       control_loop_fault_in,
  output logic                   irq
);

  // Elaboration checks
  if (ADDR_W < GDFS_ADDR_W) begin : g_chk_addr
    $error("gdfs_fault_status: ADDR_W too small for the register map");
  end
  if (NUM_SRC != GDFS_NUM_SRC) begin : g_chk_src
    $error("gdfs_fault_status: NUM_SRC must match the fault input group");
  end

  // Module state apart from the sticky event cells
  typedef struct packed {
    logic [NUM_SRC-1:0] src;        // sampled fault sources
    logic [NUM_SRC-1:0] src_prev;   // previous sample, for rise detect
    logic [31:0]        gate_flags; // gate-stage fault flags word
    logic [31:0]        ctrl_flags; // control-loop fault flags word
    logic [NUM_SRC:0]   evt_en;     // interrupt enables, msb is aggregate
    logic               agg_prev;   // previous aggregate flag
    gdfs_apb_rsp_s      rsp;        // APB answer
    logic               irq;        // interrupt line
  } gdfs_state_s;

  gdfs_state_s st_r;
  gdfs_state_s st_nxt;

  // Event bits: one per source plus aggregate
  logic [NUM_SRC:0] evt_set;
  logic [NUM_SRC:0] evt_clr;
  logic [NUM_SRC:0] evt_flag;

  // Decoded bus phases
  logic        setup_ph;
  logic        access_ph;
  logic [11:0] adr;
  logic        wr_clear;
  logic        wr_enable;
  logic        any_src;

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable & st_r.rsp.pready;
  assign adr       = paddr[11:0];

  // Write strobes take effect only at the completing access edge
  assign wr_clear  = access_ph & pwrite & (adr == GDFS_ADR_EVT_CLEAR) & pstrb[0];
  assign wr_enable = access_ph & pwrite & (adr == GDFS_ADR_EVT_ENABLE);

  // Any individual source active
  assign any_src = |st_r.src;

  // Event rise detection and software clear
  always_comb begin
    evt_set = '0;
    evt_clr = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      evt_set[i] = st_r.src[i] & ~st_r.src_prev[i];
    end
    evt_set[NUM_SRC] = st_r.gate_flags[GDFS_BIT_DRIVER_FAULT] & ~st_r.agg_prev;
    if (wr_clear) begin
      evt_clr = pwdata[NUM_SRC:0];
    end
  end

  // Sticky event cells
  for (genvar g = 0; g <= NUM_SRC; g++) begin : g_evt
    gdfs_evt_cell u_cell (
      .pclk    (pclk),
      .presetn (presetn),
      .set_i   (evt_set[g]),
      .clr_i   (evt_clr[g]),
      .flag_o  (evt_flag[g])
    );
  end

  // Next-state logic
  always_comb begin
    st_nxt = st_r;

    // Live sampling of every source each clock
    st_nxt.src      = fault_in;
    st_nxt.src_prev = st_r.src;
    st_nxt.agg_prev = st_r.gate_flags[GDFS_BIT_DRIVER_FAULT];

    // Gate-stage word; unnamed bits stay zero
    st_nxt.gate_flags = GDFS_RST_WORD;
    st_nxt.gate_flags[GDFS_BIT_OVERTEMP] = fault_in.overtemp_flag;
    st_nxt.gate_flags[GDFS_BIT_DS_OC] =
      fault_in.drain_source_overcurrent_flag;
    st_nxt.gate_flags[GDFS_BIT_SHUNT_OC] =
      fault_in.shunt_overcurrent_flag;
    st_nxt.gate_flags[GDFS_BIT_BOOT_UV] =
      fault_in.bootstrap_undervoltage_flag;
    st_nxt.gate_flags[GDFS_BIT_GATE_UV] =
      fault_in.gate_supply_undervoltage_flag;
    st_nxt.gate_flags[GDFS_BIT_SHUTDOWN] = fault_in.shutdown_pin_state;

    // Aggregate flag over all individual bits of the same word
    st_nxt.gate_flags[GDFS_BIT_DRIVER_FAULT] = |fault_in;

    // Control-loop word passes through, sampled each clock
    st_nxt.ctrl_flags = control_loop_fault_in;

    // Enable register
    if (wr_enable) begin
      if (pstrb[0]) begin
        st_nxt.evt_en = pwdata[NUM_SRC:0];
      end
    end

    // Level interrupt from enabled sticky events
    st_nxt.irq = |(evt_flag & st_r.evt_en);

    // APB answer: zero wait states, loaded during setup
    st_nxt.rsp = '0;
    if (setup_ph) begin
      st_nxt.rsp.pready = 1'b1;
      if (adr[1:0] != 2'b00) begin
        st_nxt.rsp.pslverr = 1'b1;
      end else if (adr == GDFS_ADR_GATE_FLAGS) begin
        // Read-only; a write is accepted and dropped
        if (!pwrite) begin
          st_nxt.rsp.prdata = st_r.gate_flags;
        end
      end else if (adr == GDFS_ADR_CTRL_FLAGS) begin
        if (!pwrite) begin
          st_nxt.rsp.prdata = st_r.ctrl_flags;
        end
      end else if (adr == GDFS_ADR_EVT_STATUS) begin
        if (!pwrite) begin
          st_nxt.rsp.prdata = {{(31-NUM_SRC){1'b0}}, evt_flag};
        end
      end else if (adr == GDFS_ADR_EVT_ENABLE) begin
        if (!pwrite) begin
          st_nxt.rsp.prdata = {{(31-NUM_SRC){1'b0}}, st_r.evt_en};
        end
      end else if (adr == GDFS_ADR_EVT_CLEAR) begin
        // Write-only; reads return zero
        st_nxt.rsp.prdata = GDFS_RST_WORD;
      end else begin
        // Unmapped address
        st_nxt.rsp.pslverr = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r            <= '0;
      st_r.gate_flags <= GDFS_RST_GATE_FLAGS;
      st_r.ctrl_flags <= GDFS_RST_CTRL_FLAGS;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign pready  = st_r.rsp.pready;
  assign pslverr = st_r.rsp.pslverr;
  assign prdata  = st_r.rsp.prdata;
  assign irq     = st_r.irq;

endmodule : gdfs_fault_status

// ===== gdfs_fault_status_monitor.sv
`timescale 1ns/1ps
module gdfs_fault_status_monitor
  import gdfs_pkg::*;
#(
  parameter int ADDR_W = GDFS_ADDR_W
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [31:0]       prdata,
  input wire gdfs_fault_s       fault_in
);
  gdfs_fault_s f1_r;
  gdfs_fault_s f2_r;
  logic        rd_ok;
  // Delayed copies, to know when the faults have settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f1_r <= '0;
      f2_r <= '0;
    end else begin
      f1_r <= fault_in;
      f2_r <= f1_r;
    end
  end
  // Gate register read while faults are steady
  assign rd_ok = psel && !penable && !pwrite && paddr == GDFS_ADR_GATE_FLAGS
                 && fault_in == f1_r && f1_r == f2_r;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_agg; rd_ok |=> prdata[31] == (|f1_r); endproperty
  a_agg: assert property (p_agg) else $error("bit 31 bad");
  property p_b29; rd_ok |=> prdata[29] == f1_r[5]; endproperty
  a_b29: assert property (p_b29) else $error("bit 29 bad");
  property p_b28; rd_ok |=> prdata[28] == f1_r[4]; endproperty
  a_b28: assert property (p_b28) else $error("bit 28 bad");
  property p_b27; rd_ok |=> prdata[27] == f1_r[3]; endproperty
  a_b27: assert property (p_b27) else $error("bit 27 bad");
  property p_b26; rd_ok |=> prdata[26] == f1_r[2]; endproperty
  a_b26: assert property (p_b26) else $error("bit 26 bad");
  property p_b25; rd_ok |=> prdata[25] == f1_r[1]; endproperty
  a_b25: assert property (p_b25) else $error("bit 25 bad");
  property p_b24; rd_ok |=> prdata[24] == f1_r[0]; endproperty
  a_b24: assert property (p_b24) else $error("bit 24 bad");
  property p_rsv; rd_ok |=> !prdata[30] && prdata[23:0] == 24'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_err; psel && !penable && paddr[1:0] != 2'b00 |=> pslverr; endproperty
  a_err: assert property (p_err) else $error("no error");
endmodule : gdfs_fault_status_monitor
bind gdfs_fault_status gdfs_fault_status_monitor #(.ADDR_W(ADDR_W)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata), .fault_in(fault_in));

// ===== gdfs_pkg.sv
package gdfs_pkg;

  // APB geometry
  localparam int          GDFS_ADDR_W = 12;
  localparam int          GDFS_DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [9:0]  GDFS_IDX_GATE_FLAGS = 10'h0e0;
  localparam logic [9:0]  GDFS_IDX_CTRL_FLAGS = 10'h0e2;
  localparam logic [9:0]  GDFS_IDX_EVT_STATUS = 10'h0f8;
  localparam logic [9:0]  GDFS_IDX_EVT_ENABLE = 10'h0f9;
  localparam logic [9:0]  GDFS_IDX_EVT_CLEAR  = 10'h0fa;

  // Byte addresses derived from the indices
  localparam logic [11:0] GDFS_ADR_GATE_FLAGS = {GDFS_IDX_GATE_FLAGS, 2'b00};
  localparam logic [11:0] GDFS_ADR_CTRL_FLAGS = {GDFS_IDX_CTRL_FLAGS, 2'b00};
  localparam logic [11:0] GDFS_ADR_EVT_STATUS = {GDFS_IDX_EVT_STATUS, 2'b00};
  localparam logic [11:0] GDFS_ADR_EVT_ENABLE = {GDFS_IDX_EVT_ENABLE, 2'b00};
  localparam logic [11:0] GDFS_ADR_EVT_CLEAR  = {GDFS_IDX_EVT_CLEAR, 2'b00};

  // Reset values
  localparam logic [31:0] GDFS_RST_GATE_FLAGS = 32'h0000_0000;
  localparam logic [31:0] GDFS_RST_CTRL_FLAGS = 32'h0000_0000;
  localparam logic [31:0] GDFS_RST_WORD       = 32'h0000_0000;

  // Field positions of the gate-stage fault flags register
  localparam int          GDFS_BIT_DRIVER_FAULT = 31;
  localparam int          GDFS_BIT_OVERTEMP     = 29;
  localparam int          GDFS_BIT_DS_OC        = 28;
  localparam int          GDFS_BIT_SHUNT_OC     = 27;
  localparam int          GDFS_BIT_BOOT_UV      = 26;
  localparam int          GDFS_BIT_GATE_UV      = 25;
  localparam int          GDFS_BIT_SHUTDOWN     = 24;

  // Number of individual gate-stage fault sources
  localparam int          GDFS_NUM_SRC = 6;

  // Individual fault inputs, msb first matches bits 29..24
  typedef struct packed {
    logic overtemp_flag;
    logic drain_source_overcurrent_flag;
    logic shunt_overcurrent_flag;
    logic bootstrap_undervoltage_flag;
    logic gate_supply_undervoltage_flag;
    logic shutdown_pin_state;
  } gdfs_fault_s;

  // APB answer carried as one group
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } gdfs_apb_rsp_s;

endpackage : gdfs_pkg

// ===== test_gdfs_fault_status.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_gdfs_fault_status;
  import gdfs_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, clf, d;
  logic [3:0]  pstrb;
  gdfs_fault_s flt;
  int          num_errors, n_tests;
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  gdfs_fault_status dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .fault_in(flt), .control_loop_fault_in(clf), .irq(irq));
  gdfs_apb_host host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb));
  // Bus helpers with checks
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
    host.xfer(1'b0, a, 32'h0, d, err);
    `CHK(d, e)
    `CHK(err, ee)
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    host.xfer(1'b1, a, v, d, err);
    `CHK(err, 1'b0)
  endtask : wr
  task automatic settle(input gdfs_fault_s f);
    flt <= f;
    repeat (3) @(posedge pclk);
  endtask : settle
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  // Hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    final_report();
  end
  // Test sequence
  initial begin
    presetn = 1'b0;
    flt = '0;
    clf = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(GDFS_ADR_GATE_FLAGS, GDFS_RST_GATE_FLAGS, 1'b0);
    rd(GDFS_ADR_EVT_STATUS, 32'h0, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      settle(gdfs_fault_s'(6'h01 << i));
      rd(GDFS_ADR_GATE_FLAGS, {2'b10, 6'h01 << i, 24'h0}, 1'b0);
    end
    settle('1);
    rd(GDFS_ADR_GATE_FLAGS, 32'hbf00_0000, 1'b0);
    settle('0);
    wr(GDFS_ADR_GATE_FLAGS, 32'hffff_ffff);
    rd(GDFS_ADR_GATE_FLAGS, 32'h0, 1'b0);
    $display("test bits done");
    rd(12'h384, 32'h0, 1'b1);
    rd(12'h381, 32'h0, 1'b1);
    clf <= 32'h8000_0008;
    rd(GDFS_ADR_CTRL_FLAGS, 32'h8000_0008, 1'b0);
    $display("test map done");
    rd(GDFS_ADR_EVT_STATUS, 32'h7f, 1'b0);
    wr(GDFS_ADR_EVT_CLEAR, 32'h7f);
    rd(GDFS_ADR_EVT_STATUS, 32'h0, 1'b0);
    wr(GDFS_ADR_EVT_ENABLE, 32'h7f);
    rd(GDFS_ADR_EVT_ENABLE, 32'h7f, 1'b0);
    `CHK(irq, 1'b0)
    settle(gdfs_fault_s'(6'h20));
    rd(GDFS_ADR_EVT_STATUS, 32'h60, 1'b0);
    `CHK(irq, 1'b1)
    wr(GDFS_ADR_EVT_ENABLE, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    wr(GDFS_ADR_EVT_CLEAR, 32'h7f);
    rd(GDFS_ADR_EVT_STATUS, 32'h0, 1'b0);
    $display("test events done");
    final_report();
  end
endmodule : test_gdfs_fault_status
